// file: pkg/tabc_defs.svh
`ifndef TABC_DEFS_SVH
`define TABC_DEFS_SVH
`define TABC_CLK_HZ        25000000
`define TABC_MS_CYC        (`TABC_CLK_HZ / 1000)
`define TABC_PULSE_BASE_MS 195
`define TABC_PULSE_STEP_MS 5
`define TABC_SPD_MAX_KMH   8'h0a
`define TABC_P_MIN         8'h05
`define TABC_P_MAX         8'h41
`define TABC_A_CTRL        4'h0
`define TABC_A_SPDLIM      4'h1
`define TABC_A_DEFP        4'h2
`define TABC_A_STBY        4'h3
`define TABC_A_STATUS      4'h4
`define TABC_A_TARGET      4'h5
`define TABC_A_SPEED       4'h6
`define TABC_A_MANP        4'h7
`define TABC_B_SPD_EN      0
`define TABC_B_SUP1_EN     1
`define TABC_B_SUP2_EN     2
`define TABC_B_PAR         3
`define TABC_B_NOSTBY      4
`define TABC_B_MON1_OFF    5
`define TABC_B_MON2_OFF    6
`define TABC_B_RF_EN       7
`define TABC_B_LSV         8
`define TABC_B_SEP         9
`define TABC_B_UL_CFG      10
`define TABC_B_PANEL_UL    11
`define TABC_B_PANEL_RF    12
`define TABC_PB_GRAD       8'h04
`endif

// file: pkg/tabc_pkg.sv
package tabc_pkg;
	typedef enum logic [2:0] {
		TABC_ON   = 3'b001,
		TABC_STBY = 3'b010,
		TABC_OFF  = 3'b100
	} tabc_pwr_t;
endpackage : tabc_pkg

// file: verilog/tabc_top.sv
// Notes on behaviour
// - speed signal is pwm square wave
// - pulse lasts 195 ms plus 5 ms/kmh
// - speed switch uses internal reference speed
// - supply faults checked only while powered on
// - option disables supply fault checking
// - no-standby cuts supply, else standby time
// - both supplies may switch together
// - road-finisher mode brakes at target pressure
// - manual target clamped 0.5 to 6.5 bar
// - last manual target kept across mode off
// - mode leaves above the speed limit, max 10 kmh
// - speed limit max 10, default pressure max 6.5
// - option scales pressure with load
// - fast parking pressure drop sets target
// - parking-set target cleared on reset, or on manual write unless a drop sets it that cycle
// - unloading switch enabled by cfg, switch, panel
// - shared proximity uses two separate switches
// - internal status flags mode active
// - separate mode needs proximity and switch closed
`include "tabc_defs.svh"
module tabc_top #(
	parameter int MS_CYC        = `TABC_MS_CYC,
	parameter int STBY_UNIT_CYC = `TABC_MS_CYC * 1000
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic [3:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic [7:0]  i_ref_speed,
	input  wire logic        i_ignition,
	input  wire logic        i_sup1_fault_pin,
	input  wire logic        i_sup2_fault_pin,
	input  wire logic        i_prox_pin,
	input  wire logic        i_rf_switch_pin,
	input  wire logic        i_ul_switch_pin,
	input  wire logic [7:0]  i_load_pct,
	input  wire logic [7:0]  i_park_press,
	output logic             o_general_io_slot,
	output logic             o_speed_switch_output,
	output logic             o_sup1,
	output logic             o_sup2,
	output logic             o_sup1_fault,
	output logic             o_sup2_fault,
	output logic             o_rf_brake_req,
	output logic      [7:0]  o_rf_press,
	output logic             o_rf_active,
	output logic             o_unload_level
);
	logic [12:0] ctrl;
	logic [7:0]  spd_lim;
	logic [7:0]  def_p;
	logic [7:0]  stby_t;
	logic [7:0]  man_p;
	logic        man_set;
	logic [7:0]  pb_p;
	logic        pb_set;
	logic [7:0]  pb_prev;
	logic [7:0]  spd_sw_thr;
	logic        rd_pend;
	logic [31:0] rd_q;
	logic [6:0]  s1, s2;
	tabc_pkg::tabc_pwr_t pwr;
	logic [31:0] pwm_cnt;
	logic [31:0] pwm_len;
	logic [31:0] stby_cnt;
	logic [7:0]  stby_sec;
	logic        rf_on;
	logic        rf_prev;

	function automatic logic [7:0] clamp_p(input logic [31:0] v);
		if (v < 32'(`TABC_P_MIN))
			clamp_p = `TABC_P_MIN;
		else if (v > 32'(`TABC_P_MAX))
			clamp_p = `TABC_P_MAX;
		else
			clamp_p = v[7:0];
	endfunction : clamp_p

	function automatic logic [7:0] lim8(input logic [31:0] v,
		input logic [7:0] mx);
		lim8 = (v > 32'(mx)) ? mx : v[7:0];
	endfunction : lim8

	// pin synchronisers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			s1 <= 7'h00;
		else
			s1 <= {i_ignition, i_sup1_fault_pin, i_sup2_fault_pin,
				i_prox_pin, i_rf_switch_pin, i_ul_switch_pin, 1'b0};
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			s2 <= 7'h00;
		else
			s2 <= s1;
	end

	wire ign_s  = s2[6];
	wire f1_s   = s2[5];
	wire f2_s   = s2[4];
	wire prox_s = s2[3];
	wire rfsw_s = s2[2];
	wire ulsw_s = s2[1];

	// register bus
	wire        wr_hit = i_avs_write;
	wire        rd_req = i_avs_read && !rd_pend;
	assign o_avs_waitrequest = i_avs_read && !rd_pend;
	assign o_avs_readdata    = rd_q;
	wire [7:0] status = {2'h0, o_unload_level, o_rf_active,
		o_sup2_fault, o_sup1_fault, o_sup2, o_sup1};
	logic [31:0] rd_mux;
	always_comb begin
		unique case (i_avs_address)
			`TABC_A_CTRL:   rd_mux = {19'h0, ctrl};
			`TABC_A_SPDLIM: rd_mux = {24'h0, spd_lim};
			`TABC_A_DEFP:   rd_mux = {24'h0, def_p};
			`TABC_A_STBY:   rd_mux = {24'h0, stby_t};
			`TABC_A_STATUS: rd_mux = {24'h0, status};
			`TABC_A_TARGET: rd_mux = {24'h0, o_rf_press};
			`TABC_A_SPEED:  rd_mux = {24'h0, spd_sw_thr};
			`TABC_A_MANP:   rd_mux = {24'h0, man_p};
			default:        rd_mux = 32'h0;
		endcase
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			rd_pend <= 1'b0;
		else
			rd_pend <= rd_req;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			rd_q <= 32'h0;
		else if (rd_req)
			rd_q <= rd_mux;
	end

	// per-register write strobes
	wire man_wr    = wr_hit && i_avs_address == `TABC_A_MANP;
	wire ctrl_wr   = wr_hit && i_avs_address == `TABC_A_CTRL;
	wire spdlim_wr = wr_hit && i_avs_address == `TABC_A_SPDLIM;
	wire defp_wr   = wr_hit && i_avs_address == `TABC_A_DEFP;
	wire stby_wr   = wr_hit && i_avs_address == `TABC_A_STBY;
	wire speed_wr  = wr_hit && i_avs_address == `TABC_A_SPEED;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			ctrl <= 13'h0;
		else if (ctrl_wr)
			ctrl <= i_avs_writedata[12:0];
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			spd_lim <= `TABC_SPD_MAX_KMH;
		else if (spdlim_wr)
			spd_lim <= lim8(i_avs_writedata, `TABC_SPD_MAX_KMH);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			def_p <= `TABC_P_MAX;
		else if (defp_wr)
			def_p <= lim8(i_avs_writedata, `TABC_P_MAX);
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			stby_t <= 8'h00;
		else if (stby_wr)
			stby_t <= i_avs_writedata[7:0];
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			spd_sw_thr <= 8'h00;
		else if (speed_wr)
			spd_sw_thr <= i_avs_writedata[7:0];
	end

	// speed pulse train
	wire [31:0] next_len = 32'(MS_CYC) *
		(32'(`TABC_PULSE_BASE_MS) +
		32'(`TABC_PULSE_STEP_MS) * 32'(i_ref_speed));
	wire pwm_end = pwm_cnt + 32'h1 >= pwm_len;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pwm_cnt           <= 32'h0;
			pwm_len           <= 32'h1;
			o_general_io_slot <= 1'b0;
		end else if (!ctrl[`TABC_B_SPD_EN]) begin
			pwm_cnt           <= 32'h0;
			pwm_len           <= 32'h1;
			o_general_io_slot <= 1'b0;
		end else if (pwm_end) begin
			pwm_cnt           <= 32'h0;
			pwm_len           <= next_len;
			o_general_io_slot <= !o_general_io_slot;
		end else begin
			pwm_cnt <= pwm_cnt + 32'h1;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_speed_switch_output <= 1'b0;
		else
			o_speed_switch_output <= i_ref_speed > spd_sw_thr;
	end

	// power state and steady supplies
	wire stby_done = stby_sec >= stby_t;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pwr      <= tabc_pkg::TABC_OFF;
			stby_cnt <= 32'h0;
			stby_sec <= 8'h00;
		end else begin
			unique case (pwr)
				tabc_pkg::TABC_ON: begin
					stby_cnt <= 32'h0;
					stby_sec <= 8'h00;
					if (!ign_s)
						pwr <= ctrl[`TABC_B_NOSTBY] ? tabc_pkg::TABC_OFF
							: tabc_pkg::TABC_STBY;
				end
				tabc_pkg::TABC_STBY: begin
					if (ign_s)
						pwr <= tabc_pkg::TABC_ON;
					else if (stby_done)
						pwr <= tabc_pkg::TABC_OFF;
					else if (stby_cnt + 32'h1 >= 32'(STBY_UNIT_CYC)) begin
						stby_cnt <= 32'h0;
						stby_sec <= stby_sec + 8'h01;
					end else
						stby_cnt <= stby_cnt + 32'h1;
				end
				tabc_pkg::TABC_OFF: begin
					if (ign_s)
						pwr <= tabc_pkg::TABC_ON;
				end
			endcase
		end
	end
	wire powered = pwr != tabc_pkg::TABC_OFF;
	wire en1     = ctrl[`TABC_B_SUP1_EN];
	wire en2     = ctrl[`TABC_B_PAR] ? en1 : ctrl[`TABC_B_SUP2_EN];
	wire mon_on  = pwr == tabc_pkg::TABC_ON;
	wire next_f1 = mon_on && en1 && !ctrl[`TABC_B_MON1_OFF]
		&& f1_s;
	wire next_f2 = mon_on && en2 && !ctrl[`TABC_B_MON2_OFF]
		&& f2_s;

	// supply outputs
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_sup1 <= 1'b0;
		else
			o_sup1 <= powered && en1;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_sup2 <= 1'b0;
		else
			o_sup2 <= powered && en2;
	end

	// supply fault flags
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_sup1_fault <= 1'b0;
		else
			o_sup1_fault <= next_f1;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_sup2_fault <= 1'b0;
		else
			o_sup2_fault <= next_f2;
	end

	// road-finisher mode
	wire rf_in  = ctrl[`TABC_B_SEP] ? (prox_s && rfsw_s)
		: (prox_s || ctrl[`TABC_B_PANEL_RF]);
	wire rf_req = ctrl[`TABC_B_RF_EN] && rf_in && mon_on;
	wire too_fast = i_ref_speed > spd_lim;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			rf_prev <= 1'b0;
		else
			rf_prev <= rf_req;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rf_on <= 1'b0;
		end else begin
			if (too_fast)
				rf_on <= 1'b0;
			else if (rf_req && !rf_prev)
				rf_on <= 1'b1;
			else if (!rf_req)
				rf_on <= 1'b0;
		end
	end
	assign o_rf_active = rf_on;

	wire pb_drop = rf_on && pb_prev > i_park_press
		&& (pb_prev - i_park_press) >= `TABC_PB_GRAD;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			pb_prev <= 8'h00;
		else
			pb_prev <= i_park_press;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			man_p   <= 8'h00;
			man_set <= 1'b0;
		end else if (man_wr) begin
			man_p   <= clamp_p(i_avs_writedata);
			man_set <= 1'b1;
		end
	end

	// parking-brake set target, lost on reset
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pb_p    <= 8'h00;
			pb_set  <= 1'b0;
		end else begin
			if (pb_drop) begin
				pb_p   <= clamp_p(32'(i_park_press));
				pb_set <= 1'b1;
			end else if (man_wr)
				pb_set <= 1'b0;
		end
	end
	wire [7:0]  base_p   = pb_set ? pb_p : (man_set ? man_p : def_p);
	wire [15:0] scaled   = 16'(base_p) * 16'(i_load_pct);
	wire [7:0]  eff_p    = ctrl[`TABC_B_LSV]
		? lim8(32'(scaled / 16'd100), `TABC_P_MAX) : base_p;
	wire next_ul = (ctrl[`TABC_B_UL_CFG] || ulsw_s
		|| ctrl[`TABC_B_PANEL_UL])
		&& (ctrl[`TABC_B_SEP] ? (prox_s && ulsw_s) : prox_s);

	// brake command towards the pressure controller
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_rf_brake_req <= 1'b0;
		else
			o_rf_brake_req <= rf_on;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_rf_press <= 8'h00;
		else
			o_rf_press <= rf_on ? eff_p : 8'h00;
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst)
			o_unload_level <= 1'b0;
		else
			o_unload_level <= next_ul;
	end
endmodule : tabc_top

// file: tb/tabc_top_properties.sv
module tabc_chk (
	input wire logic        i_core_clk,
	input wire logic        i_rst,
	input wire logic [3:0]  i_avs_address,
	input wire logic        i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [7:0]  i_ref_speed,
	input wire logic        i_ignition,
	input wire logic        i_prox_pin,
	input wire logic        o_general_io_slot,
	input wire logic        o_sup1,
	input wire logic        o_sup1_fault,
	input wire logic        o_rf_brake_req,
	input wire logic [7:0]  o_rf_press,
	input wire logic        o_rf_active
);
	logic [12:0] ctrl;
	wire         ctrl_wr = i_avs_write && i_avs_address == 4'h0;
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	// shadow of the control word
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) ctrl <= 13'h0000;
		else if (ctrl_wr) ctrl <= i_avs_writedata[12:0];
	end
	press_max_a: assert property (
		o_rf_press <= 8'h41) else $error("rf press high");
	press_off_a: assert property (
		!o_rf_brake_req |-> o_rf_press == 8'h00) else $error("press when off");
	status_flag_a: assert property (
		o_rf_brake_req == $past(o_rf_active)) else $error("status differs");
	speed_exit_a: assert property (
		(i_ref_speed > 8'h0a) [*4] |-> !o_rf_active) else $error("no exit");
	mon_idle_a: assert property (
		(!i_ignition) [*6] |-> !$rose(o_sup1_fault)) else $error("idle fault");
	nostby_cut_a: assert property (
		(ctrl[4] && !i_ignition) [*5] |-> !o_sup1) else $error("supply kept");
	sep_prox_a: assert property (
		(ctrl[9] && !i_prox_pin) [*5] |-> !o_rf_active) else $error("no prox");
	slot_hold_a: assert property (
		$changed(o_general_io_slot) |=> $stable(o_general_io_slot) [*8])
		else $error("pulse too short");
endmodule : tabc_chk

bind tabc_top tabc_chk u_chk (.*);

// file: tb/tabc_operator.sv
module tabc_operator (
	input  wire logic       i_clk,
	input  wire logic       i_ign_cmd,
	input  wire logic       i_prox_cmd,
	input  wire logic       i_sw_cmd,
	output logic            o_ignition = 1'b0,
	output logic            o_prox_pin = 1'b0,
	output logic            o_rf_switch_pin = 1'b0,
	output logic      [7:0] o_park_press
);
	timeunit 1ns;
	timeprecision 1ns;
	// lever left at rest: pressure held at zero, no changes
	assign o_park_press = 8'h00;
	always @(posedge i_clk) begin
		o_ignition <= i_ign_cmd;
		o_prox_pin <= i_prox_cmd;
		o_rf_switch_pin <= i_sw_cmd; // separate switch
	end
endmodule : tabc_operator

// file: tb/tabc_top_tb.sv
module tabc_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, f1 = 1'b0;
	logic ic = 1'b0, pc = 1'b0, sc = 1'b0, ign, prox, rsw;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0, rdat;
	logic [7:0] spd = 8'h00, pp, rpr;
	logic wq, slot, ssw, s1, s2, fl1, brq, ract, ul;
	int n_fail = 0, check_count = 0, cyc = 0;
	always #20 clk = ~clk;
	tabc_operator OP (.i_clk(clk), .i_ign_cmd(ic), .i_prox_cmd(pc),
		.i_sw_cmd(sc), .o_ignition(ign), .o_prox_pin(prox),
		.o_rf_switch_pin(rsw), .o_park_press(pp));
	tabc_top #(.MS_CYC(2), .STBY_UNIT_CYC(10)) DUT (.i_core_clk(clk),
		.i_rst(rst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wd), .o_avs_readdata(rdat),
		.o_avs_waitrequest(wq), .i_ref_speed(spd), .i_ignition(ign),
		.i_sup1_fault_pin(f1), .i_sup2_fault_pin(1'b0), .i_prox_pin(prox),
		.i_rf_switch_pin(rsw), .i_ul_switch_pin(1'b0), .i_load_pct(8'h64),
		.i_park_press(pp), .o_general_io_slot(slot),
		.o_speed_switch_output(ssw), .o_sup1(s1), .o_sup2(s2),
		.o_sup1_fault(fl1), .o_sup2_fault(), .o_rf_brake_req(brq),
		.o_rf_press(rpr), .o_rf_active(ract), .o_unload_level(ul));
	task test_done;
		$display("fails %0d checks %0d", n_fail, check_count);
		if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			test_done();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wrr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk iff !wq);
		wr <= 1'b0;
	endtask : wrr
	task rdd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		@(posedge clk iff !wq);
		d = rdat;
		rd <= 1'b0;
	endtask : rdd
	task step(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : step
	task t_regs;
		logic [31:0] d;
		logic [3:0] ad [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h6, 4'h8};
		logic [31:0] ev [6] = '{32'h0, 32'h0a, 32'h41, 32'h0, 32'h0, 32'h0};
		wrr(4'h1, 32'h20);
		wrr(4'h2, 32'h50);
		for (int i = 0; i < 6; i++) begin
			rdd(ad[i], d);
			chk(d, ev[i]);
		end
		$display("test regs done");
	endtask : t_regs
	task t_speed;
		wrr(4'h6, 32'h05);
		@(posedge clk) spd <= 8'h05;
		step(4);
		chk(ssw, 1'b0);
		@(posedge clk) spd <= 8'h06;
		step(4);
		chk(ssw, 1'b1);
		@(posedge clk) spd <= 8'h00;
		$display("test speed done");
	endtask : t_speed
	task t_pwm;
		int n;
		logic last;
		@(posedge clk) spd <= 8'h02;
		wrr(4'h0, 32'h01);
		@(negedge clk) last = slot;
		while (slot === last) @(negedge clk);
		last = slot;
		n = 0;
		while (slot === last) begin
			@(negedge clk);
			n++;
		end
		chk(n, 32'd410);
		wrr(4'h0, 32'h00);
		@(posedge clk) spd <= 8'h00;
		$display("test pulse done");
	endtask : t_pwm
	task t_rf;
		wrr(4'h0, 32'h280);
		@(posedge clk) pc <= 1'b1;
		ic <= 1'b1;
		step(8);
		chk(ract, 1'b0);
		chk(ul, 1'b0);
		@(posedge clk) sc <= 1'b1;
		step(8);
		chk(ract, 1'b1);
		chk(rpr, 8'h41);
		wrr(4'h7, 32'h70);
		step(4);
		chk(rpr, 8'h41);
		wrr(4'h7, 32'h02);
		step(4);
		chk(rpr, 8'h05);
		wrr(4'h7, 32'h20);
		@(posedge clk) spd <= 8'h0b;
		step(8);
		chk(ract, 1'b0);
		@(posedge clk) sc <= 1'b0;
		spd <= 8'h00;
		step(6);
		@(posedge clk) sc <= 1'b1;
		step(8);
		chk(rpr, 8'h20);
		wrr(4'h1, 32'h03);
		@(posedge clk) spd <= 8'h04;
		step(8);
		chk(ract, 1'b0);
		wrr(4'h0, 32'h400);
		step(4);
		chk(ul, 1'b1);
		@(posedge clk) spd <= 8'h00;
		ic <= 1'b0;
		pc <= 1'b0;
		sc <= 1'b0;
		step(8);
		$display("test road mode done");
	endtask : t_rf
	task t_sup;
		wrr(4'h0, 32'h12);
		@(posedge clk) f1 <= 1'b1;
		step(8);
		chk(fl1, 1'b0);
		wrr(4'h0, 32'h32);
		@(posedge clk) ic <= 1'b1;
		step(8);
		chk(s1, 1'b1);
		chk(fl1, 1'b0);
		wrr(4'h0, 32'h12);
		step(8);
		chk(fl1, 1'b1);
		@(posedge clk) ic <= 1'b0;
		f1 <= 1'b0;
		step(8);
		chk(s1, 1'b0);
		wrr(4'h3, 32'h01);
		wrr(4'h0, 32'h0a);
		@(posedge clk) ic <= 1'b1;
		step(8);
		chk(s2, 1'b1);
		@(posedge clk) ic <= 1'b0;
		step(5);
		chk(s1, 1'b1);
		step(20);
		chk(s1, 1'b0);
		$display("test supply done");
	endtask : t_sup
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_speed();
		t_pwm();
		t_rf();
		t_sup();
		test_done();
	end
endmodule : tabc_top_tb
